// [hdl/tds_pkg.sv]
package tds_pkg;
    // System clock rate and the terminate-hold time
    localparam int unsigned TDS_CLK_HZ = 25_000_000;
    localparam int unsigned TDS_TERM_HOLD_S = 2;
    localparam int unsigned TDS_TERM_HOLD_CYC = TDS_CLK_HZ * TDS_TERM_HOLD_S;
    localparam int unsigned TDS_TMR_W = 26;

    // Load/discharge-end status codes toward the transport controller
    localparam logic [1:0] TDS_STAT_NONE = 2'h0;
    localparam logic [1:0] TDS_STAT_WANT_RECEIVE = 2'h1;
    localparam logic [1:0] TDS_STAT_READY_RECEIVE = 2'h2;

    // Discharge-end command codes from the transport controller
    localparam logic [1:0] TDS_CMD_DO_NOTHING = 2'h0;
    localparam logic [1:0] TDS_CMD_GET_READY = 2'h1;
    localparam logic [1:0] TDS_CMD_START_XFER = 2'h2;

    // Register bus: one control and one status word
    localparam logic [3:0] TDS_ADDR_CTRL = 4'h0;
    localparam logic [3:0] TDS_ADDR_STAT = 4'h4;
    localparam int unsigned TDS_CTRL_START_BIT = 0;
    localparam int unsigned TDS_CTRL_DONE_BIT = 1;

    // Actuator and handshake outputs
    typedef struct packed {
        logic ld_unld_allowed;
        logic load_cmd;
        logic dis_cmd;
        logic dis_desired;
        logic seq_flag_dis;
        logic start_dis;
        logic dis_terminated;
        logic seq_term;
    } tds_out_s;

    localparam tds_out_s TDS_OUT_RST = '0;

    typedef enum logic [2:0] {
        TDS_IDLE,
        TDS_TILT_FWD,
        TDS_DISCHARGE,
        TDS_TILT_BACK,
        TDS_WAIT_IDLE_CMD,
        TDS_TERM_HOLD
    } tds_state_e;
endpackage

// [hdl/tds_sync.sv]
`timescale 1ns/1ns
// Three-stage synchroniser with agreement filter on the last two stages
module tds_sync #(
    parameter int W = 1
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    // Shift chain; first stage feeds only the second
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= i_async;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Output follows only when stages two and three agree
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            always_ff @(posedge i_clk or negedge i_rst_b) begin
                if (!i_rst_b) begin
                    o_sync[g] <= 1'b0;
                end else if (s2_q[g] == s3_q[g]) begin
                    o_sync[g] <= s3_q[g];
                end
            end
        end
    endgenerate
endmodule // tds_sync

// [hdl/tds_top.sv]
`timescale 1ns/1ns
module tds_top
    import tds_pkg::*;
#(
    parameter int unsigned P_HOLD_CYC = TDS_TERM_HOLD_CYC
) (
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic [3:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    input wire logic i_full_up,
    input wire logic i_full_down,
    input wire logic [1:0] i_dis_end_cmd,
    output logic [1:0] o_load_end_status,
    output tds_out_s o_act,
    output logic [2:0] o_state
);
    logic rst1_q;
    logic rst_b_q;
    logic [3:0] pins_s;
    logic full_up_s;
    logic full_down_s;
    logic [1:0] cmd_s;
    tds_state_e state_q;
    tds_out_s act_q;
    logic [1:0] stat_q;
    logic [TDS_TMR_W-1:0] tmr_q;
    logic start_q;
    logic done_q;
    logic start_req;
    logic done_req;
    logic go_fwd;
    logic at_up;
    logic dis_done;
    logic at_down;
    logic cmd_idle;
    logic tmr_zero;

    // Reset release through two flops
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst1_q <= 1'b0;
            rst_b_q <= 1'b0;
        end else begin
            rst1_q <= 1'b1;
            rst_b_q <= rst1_q;
        end
    end

    // Machine sensors and transport command arrive from outside
    tds_sync #(.W(4)) u_sync (
        .i_clk(i_mclk),
        .i_rst_b(rst_b_q),
        .i_async({i_full_up, i_full_down, i_dis_end_cmd}),
        .o_sync(pins_s)
    );
    assign full_up_s = pins_s[3];
    assign full_down_s = pins_s[2];
    assign cmd_s = pins_s[1:0];

    // Write decode of the control word, shared by both request strobes
    function automatic logic f_ctrl_wr(input logic wr, input logic [3:0] addr);
        return wr && (addr == TDS_ADDR_CTRL);
    endfunction

    // Software strobes: start-transfer accepted, discharge sequence done
    assign start_req = f_ctrl_wr(i_wr, i_addr) && i_wdata[TDS_CTRL_START_BIT];
    assign done_req = f_ctrl_wr(i_wr, i_addr) && i_wdata[TDS_CTRL_DONE_BIT];

    // Start-transfer flag; a new request wins over consumption
    always_ff @(posedge i_mclk or negedge rst_b_q) begin
        if (!rst_b_q) begin
            start_q <= 1'b0;
        end else if (start_req) begin
            start_q <= 1'b1;
        end else if (state_q == TDS_TILT_FWD) begin
            start_q <= 1'b0;
        end
    end

    // Discharge-done flag; kept only while the discharge step waits for it
    always_ff @(posedge i_mclk or negedge rst_b_q) begin
        if (!rst_b_q) begin
            done_q <= 1'b0;
        end else if (done_req) begin
            done_q <= 1'b1;
        end else if (state_q != TDS_DISCHARGE) begin
            done_q <= 1'b0;
        end
    end

    // Step conditions; each is qualified by its own state so at most one is true
    assign go_fwd = (state_q == TDS_IDLE) && start_q && (cmd_s == TDS_CMD_START_XFER);
    assign at_up = (state_q == TDS_TILT_FWD) && full_up_s;
    assign dis_done = (state_q == TDS_DISCHARGE) && done_q;
    assign at_down = (state_q == TDS_TILT_BACK) && full_down_s;
    assign cmd_idle = (state_q == TDS_WAIT_IDLE_CMD) && (cmd_s == TDS_CMD_DO_NOTHING);
    assign tmr_zero = (state_q == TDS_TERM_HOLD) && (tmr_q == '0);

    // State register; each step holds until its own condition is met
    always_ff @(posedge i_mclk or negedge rst_b_q) begin
        if (!rst_b_q) begin
            state_q <= TDS_IDLE;
        end else begin
            unique case (state_q)
                TDS_IDLE: begin
                    if (go_fwd) begin
                        state_q <= TDS_TILT_FWD;
                    end
                end
                TDS_TILT_FWD: begin
                    if (at_up) begin
                        state_q <= TDS_DISCHARGE;
                    end
                end
                TDS_DISCHARGE: begin
                    if (dis_done) begin
                        state_q <= TDS_TILT_BACK;
                    end
                end
                TDS_TILT_BACK: begin
                    if (at_down) begin
                        state_q <= TDS_WAIT_IDLE_CMD;
                    end
                end
                TDS_WAIT_IDLE_CMD: begin
                    if (cmd_idle) begin
                        state_q <= TDS_TERM_HOLD;
                    end
                end
                TDS_TERM_HOLD: begin
                    if (tmr_zero) begin
                        state_q <= TDS_IDLE;
                    end
                end
                default: begin
                    state_q <= TDS_IDLE;
                end
            endcase
        end
    end

    // Actuator and handshake outputs change only on the step edges
    always_ff @(posedge i_mclk or negedge rst_b_q) begin
        if (!rst_b_q) begin
            act_q <= TDS_OUT_RST;
        end else if (go_fwd) begin
            act_q.ld_unld_allowed <= 1'b1;
            act_q.dis_cmd <= 1'b1;
            act_q.dis_desired <= 1'b1; // Stands in for the earlier permission steps
            act_q.seq_flag_dis <= 1'b1; // Stands in for the earlier flag step
            act_q.start_dis <= 1'b1;
        end else if (dis_done) begin
            act_q.dis_desired <= 1'b0;
            act_q.seq_flag_dis <= 1'b0;
            act_q.dis_cmd <= 1'b0;
            act_q.start_dis <= 1'b0;
            act_q.load_cmd <= 1'b1;
            act_q.dis_terminated <= 1'b1;
        end else if (at_down) begin
            act_q.ld_unld_allowed <= 1'b0;
            act_q.load_cmd <= 1'b0;
            act_q.dis_terminated <= 1'b0;
        end else if (cmd_idle) begin
            act_q.seq_term <= 1'b1;
        end else if (tmr_zero) begin
            act_q.seq_term <= 1'b0;
        end
    end

    // Load-end status toward the transport controller
    always_ff @(posedge i_mclk or negedge rst_b_q) begin
        if (!rst_b_q) begin
            stat_q <= TDS_STAT_NONE;
        end else if (at_up) begin
            stat_q <= TDS_STAT_WANT_RECEIVE;
        end else if (tmr_zero) begin
            stat_q <= TDS_STAT_NONE;
        end
    end

    // Terminate hold timer: loaded on do-nothing, run down to zero in the hold step
    always_ff @(posedge i_mclk or negedge rst_b_q) begin
        if (!rst_b_q) begin
            tmr_q <= '0;
        end else if (cmd_idle) begin
            tmr_q <= TDS_TMR_W'(P_HOLD_CYC - 1);
        end else if ((state_q == TDS_TERM_HOLD) && (tmr_q != '0)) begin
            tmr_q <= tmr_q - 1'b1;
        end
    end

    // Outputs straight from flops
    assign o_act = act_q;
    assign o_load_end_status = stat_q;
    assign o_state = state_q;

    // Read port, data valid the cycle after the strobe
    always_ff @(posedge i_mclk or negedge rst_b_q) begin
        if (!rst_b_q) begin
            o_rdata <= '0;
        end else if (i_rd) begin
            unique case (i_addr)
                TDS_ADDR_STAT: o_rdata <= {16'h0000, act_q, 1'b0, full_up_s, full_down_s,
                    state_q, stat_q};
                TDS_ADDR_CTRL: o_rdata <= {30'h00000000, done_q, start_q};
                default: o_rdata <= 32'h00000000;
            endcase
        end else begin
            o_rdata <= 32'h00000000;
        end
    end
endmodule // tds_top

// [testbench/tds_properties.sv]
`timescale 1ns/1ns
module tds_properties
    import tds_pkg::*;
#(
    parameter int unsigned P_HOLD_CYC = TDS_TERM_HOLD_CYC
) (
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic i_full_down,
    input wire logic [1:0] i_dis_end_cmd,
    input wire logic [1:0] o_load_end_status,
    input wire tds_out_s o_act,
    input wire logic [2:0] o_state
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_b);
    // Cycles the terminate output has stood high
    logic [31:0] hold_q;
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) hold_q <= '0;
        else hold_q <= o_act.seq_term ? hold_q + 32'h1 : '0;
    end
    // Waits long enough that the input has certainly been seen
    sequence s_tilt; (o_state == 3'h3 && !i_full_down) [*5]; endsequence
    sequence s_cmd; (o_state == 3'h4 && i_dis_end_cmd != TDS_CMD_DO_NOTHING) [*5]; endsequence
    property p_want;
        o_state inside {3'h2, 3'h3, 3'h4} |-> o_load_end_status == TDS_STAT_WANT_RECEIVE;
    endproperty
    property p_fwd;
        o_state == 3'h1 |-> o_act.ld_unld_allowed && o_act.dis_cmd && o_act.start_dis
            && o_act.dis_desired && o_act.seq_flag_dis;
    endproperty
    property p_dis_off;
        o_state == 3'h3 |-> !(o_act.dis_desired || o_act.seq_flag_dis || o_act.start_dis);
    endproperty
    property p_back;
        o_state == 3'h3 |-> o_act.load_cmd && o_act.dis_terminated && !o_act.dis_cmd;
    endproperty
    property p_down_off;
        o_state == 3'h4 |-> !(o_act.ld_unld_allowed || o_act.load_cmd || o_act.dis_terminated);
    endproperty
    property p_hold_tilt; s_tilt |=> o_state == 3'h3; endproperty
    property p_hold_cmd; s_cmd |=> o_state == 3'h4 && !o_act.seq_term; endproperty
    property p_end;
        $fell(o_act.seq_term) |-> hold_q == P_HOLD_CYC && o_state == 3'h0;
    endproperty
    property p_rst; $rose(i_rst_b) |-> o_act == TDS_OUT_RST && o_state == 3'h0; endproperty
    a_want: assert property (p_want) else $error("status not want");
    a_fwd: assert property (p_fwd) else $error("forward outputs off");
    a_dis_off: assert property (p_dis_off) else $error("discharge outputs on");
    a_back: assert property (p_back) else $error("tilt back outputs wrong");
    a_down_off: assert property (p_down_off) else $error("outputs on at full down");
    a_hold_tilt: assert property (p_hold_tilt) else $error("left tilt early");
    a_hold_cmd: assert property (p_hold_cmd) else $error("left cmd wait early");
    a_end: assert property (p_end) else $error("terminate hold wrong");
    a_rst: assert property (p_rst) else $error("reset outputs wrong");
endmodule // tds_properties
bind tds_top tds_properties #(.P_HOLD_CYC(P_HOLD_CYC)) u_props (.i_mclk(i_mclk),
    .i_rst_b(i_rst_b), .i_full_down(i_full_down), .i_dis_end_cmd(i_dis_end_cmd),
    .o_load_end_status(o_load_end_status), .o_act(o_act), .o_state(o_state));

// [testbench/tds_partner.sv]
`timescale 1ns/1ns
// Tilt sensors and transport controller facing the sequencer
module tds_partner
    import tds_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic i_slow,
    input wire logic i_go,
    input wire tds_out_s i_act,
    input wire logic [1:0] i_status,
    output logic o_full_up,
    output logic o_full_down,
    output logic [1:0] o_cmd
);
    logic [4:0] tilt_q;
    logic [4:0] idle_q;
    logic [4:0] lim;
    assign lim = i_slow ? 5'h14 : 5'h01;
    // Delay counters for rear tilt and the do-nothing answer
    always_ff @(posedge i_mclk) begin
        tilt_q <= i_act.load_cmd ? tilt_q + 5'h01 : '0;
        idle_q <= (o_full_down && i_status == TDS_STAT_WANT_RECEIVE && !i_act.load_cmd) ?
            idle_q + 5'h01 : '0;
    end
    // Machine tilts forward at once, rearward after a delay
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_full_up <= 1'b0;
            o_full_down <= 1'b1;
        end else if (i_act.ld_unld_allowed && i_act.dis_cmd) begin
            o_full_up <= 1'b1;
            o_full_down <= 1'b0;
        end else if (i_act.load_cmd && tilt_q == lim) begin
            o_full_up <= 1'b0;
            o_full_down <= 1'b1;
        end
    end
    // Start transfer on request, do nothing once back at load position
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) o_cmd <= TDS_CMD_DO_NOTHING;
        else if (i_go) o_cmd <= TDS_CMD_START_XFER;
        else if (idle_q == lim) o_cmd <= TDS_CMD_DO_NOTHING;
    end
endmodule // tds_partner

// [testbench/tds_top_tb_top.sv]
`timescale 1ns/1ns
module tds_top_tb_top
    import tds_pkg::*;
;
    logic i_mclk = 1'b0;
    logic i_rst_b = 1'b0;
    logic [3:0] i_addr = 4'h0;
    logic [31:0] i_wdata = 32'h0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic slow = 1'b0;
    logic go = 1'b0;
    logic [31:0] rdata;
    logic full_up, full_down;
    logic [1:0] cmd, status;
    logic [2:0] state;
    tds_out_s act;
    int error_cnt = 0;
    int n_tests = 0;
    // 25 MHz clock
    always #20 i_mclk = ~i_mclk;
    tds_top #(.P_HOLD_CYC(8)) uut (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata), .i_full_up(full_up),
        .i_full_down(full_down), .i_dis_end_cmd(cmd), .o_load_end_status(status),
        .o_act(act), .o_state(state));
    tds_partner u_far (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_slow(slow), .i_go(go),
        .i_act(act), .i_status(status), .o_full_up(full_up), .o_full_down(full_down),
        .o_cmd(cmd));
    task automatic close_out;
        $display("Counts: %0d checks, %0d errors", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_mclk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge i_mclk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic wait_st(input logic [2:0] s);
        for (int n = 0; n < 300 && state !== s; n++) @(posedge i_mclk) #1;
        if (state !== s) begin
            cmp("state wait", 8'h01, 8'h00);
            close_out();
        end
    endtask
    task automatic t_reset;
        logic [31:0] d;
        rd(TDS_ADDR_STAT, d);
        cmp("rst act", 8'h00, d[15:8]);
        cmp("rst state", 8'h00, {3'h0, d[4:0]});
        rd(4'h8, d);
        cmp("unmapped", 8'h00, d[7:0]);
        $display("t_reset done");
    endtask
    task automatic t_cycle(input logic s);
        logic [31:0] d;
        int n;
        wr(TDS_ADDR_CTRL, 32'h1);
        slow <= s;
        go <= 1'b1;
        @(posedge i_mclk);
        go <= 1'b0;
        wait_st(3'h1);
        cmp("fwd", 8'h1F, {3'h0, act[7], act[5:2]});
        wait_st(3'h2);
        cmp("status", 8'h01, {6'h0, status});
        rd(TDS_ADDR_STAT, d);
        cmp("stat lo", 8'h49, d[7:0]);
        cmp("stat act", 8'hBC, d[15:8]);
        wr(TDS_ADDR_CTRL, 32'h2);
        wait_st(3'h3);
        cmp("back", 8'h03, {6'h0, act.load_cmd, act.dis_terminated});
        cmp("dis off", 8'h00, {4'h0, act[4:2], act.dis_cmd});
        wait_st(3'h4);
        cmp("down off", 8'h00, {5'h0, act[7:6], act.dis_terminated});
        wait_st(3'h5);
        for (n = 0; n < 50 && act.seq_term === 1'b1; n++) @(posedge i_mclk) #1;
        cmp("hold", 8'h08, n[7:0]);
        cmp("idle", 8'h00, {5'h0, state});
        cmp("idle act", 8'h00, act);
        cmp("idle status", 8'h00, {6'h0, status});
        $display("t_cycle done");
    endtask
    // Reset in mid-transfer: everything must come back idle and quiet
    task automatic t_midrst;
        logic [31:0] d;
        wr(TDS_ADDR_CTRL, 32'h1);
        go <= 1'b1;
        @(posedge i_mclk);
        go <= 1'b0;
        wait_st(3'h2);
        @(posedge i_mclk);
        i_rst_b <= 1'b0;
        repeat (2) @(posedge i_mclk);
        i_rst_b <= 1'b1;
        repeat (2) @(posedge i_mclk);
        #1;
        cmp("mid act", 8'h00, act);
        cmp("mid state", 8'h00, {3'h0, state, status});
        rd(TDS_ADDR_CTRL, d);
        cmp("mid flags", 8'h00, d[7:0]);
        $display("t_midrst done");
    endtask
    // Reset for five cycles, then the scenarios
    initial begin
        repeat (5) @(posedge i_mclk);
        i_rst_b <= 1'b1;
        repeat (3) @(posedge i_mclk);
        t_reset();
        t_cycle(1'b0);
        t_midrst();
        t_cycle(1'b1);
        close_out();
    end
endmodule // tds_top_tb_top
